// file: hw/dasc_ctrl.sv
`timescale 1ns/10ps
// Overview of operation
// - Results are 16 bits; boost with valid oversampling gives 18-bit results.
// - Alert event when a result is above the high or below the low limit.
// - Alert status holds a high and a low flag per channel.
// - Flags ORed to one alert, driven on second pin when selected, enabled, valid.
// - Alert pin and status update at each conversion end; host reads in time.
// - Chip-select fall clears the alert pin; software reset clears alert status.
// - Power-mode bit 0 is normal, 1 is shutdown; normal converts on select fall.
// - Shutdown powers down analog and reference; serial and settings stay.
// - Reference select 0 enables internal reference buffer, 1 disables it.
// - Reset codes written to the 8-bit reset field pick soft or hard reset.
// - Soft reset keeps configuration, restarts logic, flushes averaging, clears alerts.
// - Hard reset also restores defaults and resets reference buffer and oscillator.
// - Self-test after power-on or hard reset sets setup-fail on failure.
// - Select fall holds both channels, starts both conversions, enables outputs.
// - Conversion timing comes from the internal clock, not the serial clock.
// - A frame shifts out the result of the previous frame's conversion.
// - MSB appears at select fall; later bits shift on serial clock rising edges.
// - Averaging active only with mode bit set and nonzero ratio field.
// - Two-line mode sends channel A on primary, channel B on second pin.
// - One-line mode sends A then B on the primary output.
module dasc_ctrl (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Configuration and reset command
  input wire logic cfg_wr_i,
  input wire dasc_pkg::dasc_cfg_s cfg_i,
  input wire logic rst_cmd_wr_i,
  input wire logic [7:0] rst_cmd_i,
  // Converter samples
  input wire logic [15:0] sample_a_i,
  input wire logic [15:0] sample_b_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  output logic primary_data_out_o,
  output logic primary_data_oe_o,
  output logic second_out_or_flag_pin_o,
  output logic second_out_or_flag_pin_oe_o,
  // Status and analog control
  output dasc_pkg::dasc_cfg_s cfg_o,
  output logic [3:0] alert_status_o,
  output logic setup_fail_o,
  output logic hold_o,
  output logic analog_pd_o,
  output logic ref_buf_en_o,
  output logic ref_rst_o,
  output logic osc_rst_o
);

  function automatic logic code_hit(input logic [7:0] code, input logic [7:0] key);
    code_hit = (code == key);
  endfunction

  // Result scaled by ratio, left aligned in 18 bits
  function automatic logic [17:0] scale(input logic [18:0] s, input logic [1:0] sh, input logic bst);
    logic [20:0] w;
    w = {s, 2'h0} >> sh;
    scale = bst ? w[17:0] : {w[17:2], 2'h0};
  endfunction

  // Returns {below low, above high}
  function automatic logic [1:0] lim_cmp(input logic [17:0] v, input dasc_pkg::dasc_cfg_s c);
    lim_cmp = {v[17:2] < c.alert_lo, v[17:2] > c.alert_hi};
  endfunction

  logic cs_m_r, cs_s_r, cs_d_r;
  logic sck_m_r, sck_s_r, sck_d_r;
  logic cs_fall, cs_rise, sck_rise;
  logic soft_r, hard_r, sw_rst;
  dasc_pkg::dasc_cfg_s cfg_r;
  logic os_on, boost_on, lim_ok, alert_mode, one_line;
  dasc_pkg::dasc_cv_e cv_r;
  logic [dasc_pkg::CONV_CW-1:0] cv_cnt_r;
  logic conv_end, conv_start;
  logic [15:0] fa_r [dasc_pkg::FIFO_DEPTH];
  logic [15:0] fb_r [dasc_pkg::FIFO_DEPTH];
  logic fill_r, reference_select_bit_d_r;
  logic [1:0] shamt;
  logic [18:0] sum_a, sum_b;
  logic [17:0] res_a, res_b;
  dasc_pkg::dasc_res_s buf_r [dasc_pkg::BUF_DEPTH];
  dasc_pkg::dasc_res_s head;
  logic wp_r, rp_r;
  logic [1:0] cnt_r;
  logic in_vld, in_rdy, out_vld, out_rdy, push_b, pop_b;
  logic [3:0] flags;
  logic [3:0] alert_status_r;
  logic alert_pin_r;
  logic [35:0] sh_p_r;
  logic [17:0] sh_s_r;
  logic frame_r, sec_r, sec_oe_r;
  logic [dasc_pkg::ST_CW-1:0] st_cnt_r;
  logic st_run_r, setup_fail_r;

  // Pin synchronisers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_m_r <= 1'h1;
      cs_s_r <= 1'h1;
      cs_d_r <= 1'h1;
      sck_m_r <= 1'h0;
      sck_s_r <= 1'h0;
      sck_d_r <= 1'h0;
    end
    else if (clk_en_i)
    begin
      cs_m_r <= cs_n_i;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      sck_m_r <= sclk_i;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
    end
  end

  assign cs_fall = cs_d_r & ~cs_s_r;
  assign cs_rise = ~cs_d_r & cs_s_r;
  assign sck_rise = ~sck_d_r & sck_s_r & ~cs_s_r;

  // Software reset decode
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      soft_r <= 1'h0;
      hard_r <= 1'h0;
    end
    else if (clk_en_i)
    begin
      soft_r <= rst_cmd_wr_i & code_hit(rst_cmd_i, dasc_pkg::SOFT_RST_CODE);
      hard_r <= rst_cmd_wr_i & code_hit(rst_cmd_i, dasc_pkg::HARD_RST_CODE);
    end
  end

  assign sw_rst = soft_r | hard_r;

  // Configuration, untouched by soft reset and shutdown
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_r <= dasc_pkg::CFG_DEF;
    else if (clk_en_i)
    begin
      if (hard_r)
        cfg_r <= dasc_pkg::CFG_DEF;
      else if (cfg_wr_i)
        cfg_r <= cfg_i;
    end
  end

  assign cfg_o = cfg_r;
  assign os_on = cfg_r.oversample_mode_bit & (cfg_r.oversample_ratio_field != 3'h0);
  assign boost_on = os_on & cfg_r.res;
  assign lim_ok = cfg_r.alert_hi > cfg_r.alert_lo;
  assign alert_mode = cfg_r.osel & cfg_r.alert_en & lim_ok;
  assign one_line = cfg_r.osel;

  // Analog power and reference control
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      analog_pd_o <= 1'h0;
      ref_buf_en_o <= 1'h0;
      ref_rst_o <= 1'h0;
      osc_rst_o <= 1'h0;
    end
    else if (clk_en_i)
    begin
      analog_pd_o <= cfg_r.power_mode_bit;
      ref_buf_en_o <= ~cfg_r.reference_select_bit & ~cfg_r.power_mode_bit;
      ref_rst_o <= hard_r;
      osc_rst_o <= hard_r;
    end
  end

  // Conversion sequencer, timed by the core clock only
  assign conv_start = cs_fall & ~cfg_r.power_mode_bit;
  assign conv_end = (cv_r == dasc_pkg::CV_RUN) && (cv_cnt_r == dasc_pkg::CONV_LAST) && !sw_rst;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cv_r <= dasc_pkg::CV_IDLE;
      cv_cnt_r <= '0;
      hold_o <= 1'h0;
    end
    else if (clk_en_i)
    begin
      if (sw_rst)
      begin
        cv_r <= dasc_pkg::CV_IDLE;
        hold_o <= 1'h0;
      end
      else
      begin
        unique case (cv_r)
          dasc_pkg::CV_IDLE:
          begin
            if (conv_start)
            begin
              cv_r <= dasc_pkg::CV_RUN;
              cv_cnt_r <= '0;
              hold_o <= 1'h1;
            end
          end
          dasc_pkg::CV_RUN:
          begin
            if (cv_cnt_r == dasc_pkg::CONV_LAST)
            begin
              cv_r <= dasc_pkg::CV_AVG;
              hold_o <= 1'h0;
            end
            else
              cv_cnt_r <= cv_cnt_r + 1'h1;
          end
          dasc_pkg::CV_AVG:
          begin
            if (in_rdy)
            begin
              cv_r <= conv_start ? dasc_pkg::CV_RUN : dasc_pkg::CV_IDLE;
              cv_cnt_r <= '0;
              hold_o <= conv_start;
            end
          end
        endcase
      end
    end
  end

  // Averaging history, refilled after reset or reference change
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fill_r <= 1'h1;
      reference_select_bit_d_r <= 1'h0;
    end
    else if (clk_en_i)
    begin
      reference_select_bit_d_r <= cfg_r.reference_select_bit;
      if (sw_rst || (reference_select_bit_d_r != cfg_r.reference_select_bit))
        fill_r <= 1'h1;
      else if (conv_end)
        fill_r <= 1'h0;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (clk_en_i && conv_end)
    begin
      for (int i = 0; i < dasc_pkg::FIFO_DEPTH; i++)
      begin
        fa_r[i] <= (fill_r || i == 0) ? sample_a_i : fa_r[(i == 0) ? 0 : i - 1];
        fb_r[i] <= (fill_r || i == 0) ? sample_b_i : fb_r[(i == 0) ? 0 : i - 1];
      end
    end
  end

  // Rolling sum over the newest 2^shamt samples
  always_comb
  begin
    shamt = 2'h0;
    if (os_on)
      shamt = (cfg_r.oversample_ratio_field > dasc_pkg::OSR_MAX) ? 2'h3 : cfg_r.oversample_ratio_field[1:0];
    sum_a = '0;
    sum_b = '0;
    for (int i = 0; i < dasc_pkg::FIFO_DEPTH; i++)
    begin
      if (i < (1 << shamt))
      begin
        sum_a = sum_a + 19'(fa_r[i]);
        sum_b = sum_b + 19'(fb_r[i]);
      end
    end
  end

  assign res_a = scale(sum_a, shamt, boost_on);
  assign res_b = scale(sum_b, shamt, boost_on);

  // Two-entry result buffer between converter and serial port
  assign in_vld = (cv_r == dasc_pkg::CV_AVG);
  assign in_rdy = (cnt_r != 2'h2);
  assign out_vld = (cnt_r != 2'h0);
  assign out_rdy = cs_fall;
  assign push_b = in_vld & in_rdy & ~sw_rst;
  assign pop_b = out_vld & out_rdy;
  assign head = buf_r[rp_r];

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_r <= 1'h0;
      rp_r <= 1'h0;
      cnt_r <= 2'h0;
    end
    else if (clk_en_i)
    begin
      if (sw_rst)
      begin
        wp_r <= 1'h0;
        rp_r <= 1'h0;
        cnt_r <= 2'h0;
      end
      else
      begin
        if (push_b)
          wp_r <= ~wp_r;
        if (pop_b)
          rp_r <= ~rp_r;
        cnt_r <= cnt_r + {1'h0, push_b} - {1'h0, pop_b};
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (clk_en_i && push_b)
      buf_r[wp_r] <= '{boost: boost_on, a: res_a, b: res_b};
  end

  // Alert flags and pin
  assign flags = {lim_cmp(res_b, cfg_r), lim_cmp(res_a, cfg_r)};

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      alert_status_r <= 4'h0;
      alert_pin_r <= 1'h0;
    end
    else if (clk_en_i)
    begin
      if (push_b)
        alert_status_r <= flags;
      else if (sw_rst)
        alert_status_r <= 4'h0;
      if (push_b)
        alert_pin_r <= |flags;
      else if (cs_fall || sw_rst)
        alert_pin_r <= 1'h0;
    end
  end

  assign alert_status_o = alert_status_r;

  // Serial shift registers, loaded at select fall
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sh_p_r <= '0;
      sh_s_r <= '0;
      frame_r <= 1'h0;
    end
    else if (clk_en_i)
    begin
      if (sw_rst)
      begin
        sh_p_r <= '0;
        sh_s_r <= '0;
        frame_r <= 1'h0;
      end
      else if (cs_fall)
      begin
        frame_r <= 1'h1;
        if (!out_vld)
        begin
          sh_p_r <= '0;
          sh_s_r <= '0;
        end
        else if (one_line)
        begin
          sh_p_r <= head.boost ? {head.a, head.b} : {head.a[17:2], head.b[17:2], 4'h0};
          sh_s_r <= '0;
        end
        else
        begin
          sh_p_r <= {head.a, 18'h0};
          sh_s_r <= head.b;
        end
      end
      else if (cs_rise)
        frame_r <= 1'h0;
      else if (sck_rise && frame_r)
      begin
        sh_p_r <= {sh_p_r[34:0], 1'h0};
        sh_s_r <= {sh_s_r[16:0], 1'h0};
      end
    end
  end

  assign primary_data_out_o = sh_p_r[35];
  assign primary_data_oe_o = frame_r;

  // Second pin carries channel B or the alert
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sec_r <= 1'h0;
      sec_oe_r <= 1'h0;
    end
    else if (clk_en_i)
    begin
      sec_r <= alert_mode ? alert_pin_r : sh_s_r[17];
      sec_oe_r <= alert_mode | (frame_r & ~one_line);
    end
  end

  assign second_out_or_flag_pin_o = sec_r;
  assign second_out_or_flag_pin_oe_o = sec_oe_r;

  // Configuration self-test after power-on or hard reset
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_run_r <= 1'h1;
      st_cnt_r <= '0;
      setup_fail_r <= 1'h0;
    end
    else if (clk_en_i)
    begin
      if (hard_r)
      begin
        st_run_r <= 1'h1;
        st_cnt_r <= '0;
        setup_fail_r <= 1'h0;
      end
      else if (st_run_r)
      begin
        if (st_cnt_r == dasc_pkg::ST_LAST)
        begin
          st_run_r <= 1'h0;
          setup_fail_r <= (cfg_r != dasc_pkg::CFG_DEF);
        end
        else
          st_cnt_r <= st_cnt_r + 1'h1;
      end
    end
  end

  assign setup_fail_o = setup_fail_r;

endmodule

// file: inc/dasc_pkg.sv
package dasc_pkg;

  // Timing at the core clock rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 500;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CW = $clog2(CONV_CYC + 1);
  localparam logic [CONV_CW-1:0] CONV_LAST = CONV_CW'(CONV_CYC - 1);
  localparam int SELFTEST_TIME_NS = 200;
  localparam int ST_CYC = (SELFTEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST_CW = $clog2(ST_CYC + 1);
  localparam logic [ST_CW-1:0] ST_LAST = ST_CW'(ST_CYC - 1);

  // Data path sizes
  localparam int SMP_W = 16;
  localparam int RES_W = 18;
  localparam int SUM_W = 19;
  localparam int FIFO_DEPTH = 8;
  localparam int BUF_DEPTH = 2;

  // Reset command codes
  localparam logic [7:0] SOFT_RST_CODE = 8'h3C;
  localparam logic [7:0] HARD_RST_CODE = 8'hFF;

  // Largest ratio code honoured, ratio 8
  localparam logic [2:0] OSR_MAX = 3'h3;

  // Alert status bit positions
  localparam int ALR_A_HI = 0;
  localparam int ALR_A_LO = 1;
  localparam int ALR_B_HI = 2;
  localparam int ALR_B_LO = 3;

  typedef struct packed {
    logic power_mode_bit;
    logic reference_select_bit;
    logic osel;
    logic oversample_mode_bit;
    logic [2:0] oversample_ratio_field;
    logic res;
    logic alert_en;
    logic [SMP_W-1:0] alert_hi;
    logic [SMP_W-1:0] alert_lo;
  } dasc_cfg_s;

  localparam dasc_cfg_s CFG_DEF = '{power_mode_bit: 1'h0, reference_select_bit: 1'h0, osel: 1'h0, oversample_mode_bit: 1'h0,
    oversample_ratio_field: 3'h0, res: 1'h0, alert_en: 1'h0, alert_hi: 16'hFFFF, alert_lo: 16'h0000};

  typedef struct packed {
    logic boost;
    logic [RES_W-1:0] a;
    logic [RES_W-1:0] b;
  } dasc_res_s;

  typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_AVG} dasc_cv_e;

endpackage

// file: verif/dasc_ctrl_checker.sv
`timescale 1ns/10ps
module dasc_ctrl_checker (
  // Clock, reset, commands
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic rst_cmd_wr_i,
  input wire logic [7:0] rst_cmd_i,
  input wire logic cs_n_i,
  // Observed outputs
  input wire logic primary_data_oe_o,
  input wire logic second_out_or_flag_pin_o,
  input wire logic second_out_or_flag_pin_oe_o,
  input wire dasc_pkg::dasc_cfg_s cfg_o,
  input wire logic [3:0] alert_status_o,
  input wire logic hold_o,
  input wire logic ref_buf_en_o,
  input wire logic ref_rst_o,
  input wire logic osc_rst_o
);
  localparam int HOLD_CYC = dasc_pkg::CONV_CYC;
  logic alert_mode;
  logic [7:0] hold_cnt_r;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  assign alert_mode = cfg_o.osel && cfg_o.alert_en && (cfg_o.alert_hi > cfg_o.alert_lo);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hold_cnt_r <= 8'h00;
    else if (hold_o)
      hold_cnt_r <= hold_cnt_r + 8'h01;
    else
      hold_cnt_r <= 8'h00;
  end

  sequence hard_pulse;
    ref_rst_o && osc_rst_o && cfg_o == dasc_pkg::CFG_DEF ##1 !ref_rst_o && !osc_rst_o;
  endsequence

  a_oe_idle_off: assert property (cs_n_i [*6] |-> !primary_data_oe_o)
    else $error("primary output driven outside frame");
  a_oe_frame_on: assert property (!cs_n_i [*6] |-> primary_data_oe_o)
    else $error("primary output not driven in frame");
  a_hold_start: assert property ($rose(hold_o) |-> !cs_n_i && $past(cs_n_i, 8) && primary_data_oe_o)
    else $error("hold without select fall");
  a_hold_len: assert property ($fell(hold_o) |-> hold_cnt_r == 8'(HOLD_CYC))
    else $error("conversion length wrong");
  a_ref_buf: assert property ($stable({cfg_o.power_mode_bit, cfg_o.reference_select_bit}) && !$past(rst_i)
    |-> ref_buf_en_o == (!cfg_o.reference_select_bit && !cfg_o.power_mode_bit))
    else $error("reference buffer enable wrong");
  a_alert_clear: assert property (alert_mode && $rose(primary_data_oe_o) |-> ##[0:1] !second_out_or_flag_pin_o)
    else $error("flag pin not cleared by select");
  a_alert_or: assert property (alert_mode && $changed(alert_status_o)
    |-> ##[0:1] second_out_or_flag_pin_o == (|alert_status_o))
    else $error("flag pin differs from status");
  a_alert_drive: assert property (alert_mode && $past(alert_mode, 3) |-> second_out_or_flag_pin_oe_o)
    else $error("flag pin not driven");
  a_soft_rst: assert property (rst_cmd_wr_i && rst_cmd_i == dasc_pkg::SOFT_RST_CODE
    |-> ##2 alert_status_o == 4'h0 && !ref_rst_o && $stable(cfg_o))
    else $error("soft reset effect wrong");
  a_hard_rst: assert property (rst_cmd_wr_i && rst_cmd_i == dasc_pkg::HARD_RST_CODE |-> ##2 hard_pulse)
    else $error("hard reset effect wrong");
endmodule

bind dasc_ctrl dasc_ctrl_checker dasc_ctrl_checker_i (.core_clk_i, .rst_i, .rst_cmd_wr_i, .rst_cmd_i, .cs_n_i,
  .primary_data_oe_o, .second_out_or_flag_pin_o, .second_out_or_flag_pin_oe_o, .cfg_o, .alert_status_o,
  .hold_o, .ref_buf_en_o, .ref_rst_o, .osc_rst_o);

// file: verif/dasc_ctrl_tb.sv
`timescale 1ns/10ps
module dasc_ctrl_tb;
  logic core_clk_i;
  logic rst_i;
  logic cfg_wr_i;
  logic rst_cmd_wr_i;
  logic [7:0] rst_cmd_i;
  logic [15:0] sample_a_i;
  logic [15:0] sample_b_i;
  logic cs_n, sclk, p_do, p_oe, s_do, s_oe, setup_fail, hold, pd, ref_en, ref_rst, osc_rst, clk_en;
  int n_hold = 0;
  logic [3:0] status;
  dasc_pkg::dasc_cfg_s cfg_i;
  dasc_pkg::dasc_cfg_s cfg_o;
  dasc_pkg::dasc_cfg_s c;
  int n_fail;
  int n_compared;

  dasc_ctrl dasc_ctrl_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .cfg_wr_i(cfg_wr_i),
    .cfg_i(cfg_i), .rst_cmd_wr_i(rst_cmd_wr_i), .rst_cmd_i(rst_cmd_i), .sample_a_i(sample_a_i),
    .sample_b_i(sample_b_i), .cs_n_i(cs_n), .sclk_i(sclk), .primary_data_out_o(p_do),
    .primary_data_oe_o(p_oe), .second_out_or_flag_pin_o(s_do), .second_out_or_flag_pin_oe_o(s_oe),
    .cfg_o(cfg_o), .alert_status_o(status), .setup_fail_o(setup_fail), .hold_o(hold),
    .analog_pd_o(pd), .ref_buf_en_o(ref_en), .ref_rst_o(ref_rst), .osc_rst_o(osc_rst));

  dasc_host dasc_host_i (.cs_n_o(cs_n), .sclk_o(sclk), .sdo_p_i(p_do), .sdo_p_oe_i(p_oe), .sdo_s_i(s_do),
    .sdo_s_oe_i(s_oe));

  // Cycles spent in hold
  always @(posedge core_clk_i)
    if (hold === 1'b1)
      n_hold <= n_hold + 1;

  task automatic chk(input string what, input logic [40:0] seen, input logic [40:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic set_cfg(input dasc_pkg::dasc_cfg_s v);
    @(posedge core_clk_i);
    cfg_i <= v;
    cfg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    cfg_wr_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  task automatic cmd(input logic [7:0] code);
    @(posedge core_clk_i);
    rst_cmd_i <= code;
    rst_cmd_wr_i <= 1'b1;
    @(posedge core_clk_i);
    rst_cmd_wr_i <= 1'b0;
    repeat (30) @(posedge core_clk_i);
    #1;
  endtask

  task automatic smp(input logic [15:0] a, input logic [15:0] b);
    @(posedge core_clk_i);
    sample_a_i <= a;
    sample_b_i <= b;
    #1;
  endtask

  task automatic t_latency();
    smp(16'hA5C3, 16'h3C5A);
    dasc_host_i.frame(16);
    smp(16'h0F81, 16'hE817);
    dasc_host_i.frame(16);
    chk("word a", dasc_host_i.rx_p[15:0], 16'hA5C3);
    chk("word b", dasc_host_i.rx_s[15:0], 16'h3C5A);
    dasc_host_i.frame(16);
    chk("next a", dasc_host_i.rx_p[15:0], 16'h0F81);
  endtask

  task automatic t_boost();
    c = dasc_pkg::CFG_DEF;
    c.osel = 1'b1;
    c.oversample_mode_bit = 1'b1;
    c.oversample_ratio_field = 3'h1;
    c.res = 1'b1;
    set_cfg(c);
    smp(16'h0F82, 16'hE818);
    dasc_host_i.frame(36);
    dasc_host_i.frame(36);
    chk("boosted", dasc_host_i.rx_p, {16'h0F81, 2'h2, 16'hE817, 2'h2});
    for (int i = 0; i < 2; i++)
    begin
      c.oversample_mode_bit = i[0];
      c.oversample_ratio_field = {2'h0, !i[0]};
      set_cfg(c);
      dasc_host_i.frame(32);
      dasc_host_i.frame(32);
      chk("plain", dasc_host_i.rx_p[31:0], {16'h0F82, 16'hE818});
    end
  endtask

  task automatic t_alert();
    c = dasc_pkg::CFG_DEF;
    c.osel = 1'b1;
    c.alert_en = 1'b1;
    c.alert_hi = 16'h8000;
    c.alert_lo = 16'h1000;
    set_cfg(c);
    smp(16'h9000, 16'h0800);
    dasc_host_i.frame(32);
    dasc_host_i.frame(32);
    chk("status", status, 4'h9);
    chk("flag pin", {s_oe, s_do}, 2'h3);
    chk("words", dasc_host_i.rx_p[31:0], 32'h90000800);
    cmd(dasc_pkg::SOFT_RST_CODE);
    chk("status soft", status, 4'h0);
    chk("cfg soft", cfg_o, c);
    c.alert_hi = 16'h1000;
    set_cfg(c);
    chk("flag off", s_oe, 1'b0);
    cmd(8'h55);
    chk("cfg odd code", cfg_o, c);
    cmd(dasc_pkg::HARD_RST_CODE);
    chk("cfg hard", cfg_o, dasc_pkg::CFG_DEF);
    chk("self test", setup_fail, 1'b0);
    // Config written while the self-test runs must flag a failure
    @(posedge core_clk_i);
    rst_cmd_i <= dasc_pkg::HARD_RST_CODE;
    rst_cmd_wr_i <= 1'b1;
    @(posedge core_clk_i);
    rst_cmd_wr_i <= 1'b0;
    set_cfg(c);
    repeat (30) @(posedge core_clk_i);
    #1;
    chk("self test fail", setup_fail, 1'b1);
    cmd(dasc_pkg::HARD_RST_CODE);
    chk("self test pass", setup_fail, 1'b0);
  endtask

  task automatic t_power();
    int h;
    c = dasc_pkg::CFG_DEF;
    c.power_mode_bit = 1'b1;
    set_cfg(c);
    chk("shutdown", {pd, ref_en}, 2'h2);
    h = n_hold;
    dasc_host_i.frame(16);
    chk("no conversion", 41'(n_hold - h), 41'h0);
    c.power_mode_bit = 1'b0;
    c.reference_select_bit = 1'b1;
    set_cfg(c);
    repeat (20) @(posedge core_clk_i);
    #1;
    chk("external ref", {pd, ref_en}, 2'h0);
    chk("cfg kept", cfg_o, c);
    h = n_hold;
    dasc_host_i.frame(16);
    chk("conversion", 41'(n_hold - h), 41'(dasc_pkg::CONV_CYC));
  endtask

  // Clock enable low must ignore a config write
  task automatic t_freeze();
    @(posedge core_clk_i);
    clk_en <= 1'b0;
    cfg_i <= dasc_pkg::CFG_DEF;
    cfg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    cfg_wr_i <= 1'b0;
    @(posedge core_clk_i);
    clk_en <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("frozen cfg", cfg_o, c);
  endtask

  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    #400000;
    n_fail++;
    close_out();
  end

  initial
  begin
    rst_i = 1'b1;
    cfg_wr_i = 1'b0;
    cfg_i = dasc_pkg::CFG_DEF;
    rst_cmd_wr_i = 1'b0;
    rst_cmd_i = 8'h00;
    sample_a_i = 16'h0000;
    sample_b_i = 16'h0000;
    clk_en = 1'b1;
    n_fail = 0;
    n_compared = 0;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (30) @(posedge core_clk_i);
    #1;
    chk("cfg reset", cfg_o, dasc_pkg::CFG_DEF);
    chk("setup reset", setup_fail, 1'b0);
    chk("power reset", {pd, ref_en, p_oe}, 3'h2);
    t_latency();
    t_boost();
    t_alert();
    t_power();
    t_freeze();
    close_out();
  end
endmodule

// file: verif/dasc_host.sv
`timescale 1ns/10ps
module dasc_host (
  // Serial pins
  output logic cs_n_o,
  output logic sclk_o,
  input wire logic sdo_p_i,
  input wire logic sdo_p_oe_i,
  input wire logic sdo_s_i,
  input wire logic sdo_s_oe_i
);
  logic [35:0] rx_p;
  logic [35:0] rx_s;

  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    rx_p = '0;
    rx_s = '0;
  end

  // One whole access per frame; clock idles low between frames
  task automatic frame(input int n);
    #3;
    rx_p = '0;
    rx_s = '0;
    cs_n_o = 1'b0;
    #100;
    repeat (n)
    begin
      // Undriven line reads as the inverse of the bit on the pin
      rx_p = {rx_p[34:0], sdo_p_oe_i ? sdo_p_i : ~sdo_p_i};
      rx_s = {rx_s[34:0], sdo_s_oe_i ? sdo_s_i : ~sdo_s_i};
      sclk_o = 1'b1;
      #40;
      sclk_o = 1'b0;
      #40;
    end
    cs_n_o = 1'b1;
    #200;
  endtask
endmodule
